//--- src/dppc_pkg.sv
// Constants and types for downstream port power control
package dppc_pkg;

  // ----------------------------------------
  // Clock and timing
  // ----------------------------------------
  localparam int CLK_HZ = 20000000;
  localparam int VCONN_BLANK_US = 100;
  localparam int VCONN_BLANK_CYC = (VCONN_BLANK_US * (CLK_HZ / 1000000) > 0) ?
                                   VCONN_BLANK_US * (CLK_HZ / 1000000) : 1;
  localparam int DISCHARGE_MAX_MS = 50;
  localparam int DISCHARGE_MAX_CYC = DISCHARGE_MAX_MS * (CLK_HZ / 1000);
  localparam int BLANK_W = 12;
  localparam int DSC_W = 24;

  // ----------------------------------------
  // Register bus
  // ----------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] TYPEC_OFF = 8'h04;
  localparam logic [7:0] STATUS_OFF = 8'h08;
  localparam logic [7:0] MASK_OFF = 8'h0c;
  localparam logic [7:0] LIVE_OFF = 8'h10;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int NPORT = 4;
  localparam int CTRL_SPLIT_BIT = 4;
  localparam int CTRL_SS3_BIT = 5;
  localparam int TC_P2_BASE = 4;
  localparam int TC_CC1_BIT = 0;
  localparam int TC_CC2_BIT = 1;
  localparam int TC_DSC_BIT = 2;
  localparam int ST_W = 10;
  localparam int NSYNC = 10;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [5:0] CTRL_RST = 6'h00;
  localparam logic [7:0] TYPEC_RST = 8'h00;
  localparam logic [9:0] STATUS_RST = 10'h000;
  localparam logic [9:0] MASK_RST = 10'h000;

  // ----------------------------------------
  // Discharge sequencer states
  // ----------------------------------------
  typedef enum logic [0:0] {
    DSC_IDLE = 1'b0,
    DSC_RUN = 1'b1
  } dppc_dsc_e;

endpackage

//--- src/dppc_sync.sv
// Two flip-flop synchroniser for a vector of pin levels
module dppc_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Levels
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] d_out
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= RST_VAL;
      sync_reg <= RST_VAL;
    end else begin
      meta_reg <= d_in;
      sync_reg <= meta_reg;
    end
  end

  assign d_out = sync_reg;

endmodule // dppc_sync

//--- src/dppc_typec.sv
// VCONN and VBUS discharge control for one Type-C port
module dppc_typec #(
  parameter int DSC_MAX = dppc_pkg::DISCHARGE_MAX_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic port_en,
  input wire logic cc1_req,
  input wire logic cc2_req,
  input wire logic dsc_start,
  // Synchronised sense
  input wire logic cc1_ok,
  input wire logic cc2_ok,
  input wire logic vbus_safe0,
  // Drives and events
  output logic vconn_cc1_en,
  output logic vconn_cc2_en,
  output logic discharge_en,
  output logic fault_cc1,
  output logic fault_cc2,
  output logic dsc_timeout
);

  localparam logic [dppc_pkg::BLANK_W-1:0] BLANK_LAST =
    dppc_pkg::BLANK_W'(dppc_pkg::VCONN_BLANK_CYC - 1);
  localparam logic [dppc_pkg::DSC_W-1:0] DSC_LAST = dppc_pkg::DSC_W'(DSC_MAX - 1);

  logic [1:0] trip_reg, trip_next;
  logic [dppc_pkg::BLANK_W-1:0] blank1_reg, blank1_next, blank2_reg, blank2_next;
  logic [dppc_pkg::DSC_W-1:0] dcnt_reg, dcnt_next;
  dppc_pkg::dppc_dsc_e dst_reg, dst_next;
  wire want1 = port_en & cc1_req & ~trip_reg[0];
  wire want2 = port_en & cc2_req & ~trip_reg[1];
  wire settled1 = (blank1_reg == BLANK_LAST);
  wire settled2 = (blank2_reg == BLANK_LAST);

  // Off at reset and for a disabled port
  assign vconn_cc1_en = want1;
  assign vconn_cc2_en = want2;
  // Fault: enabled, blanking over, line not above 3.0V
  assign fault_cc1 = want1 & settled1 & ~cc1_ok;
  assign fault_cc2 = want2 & settled2 & ~cc2_ok;
  // Tripped line stays off until its request is dropped
  assign trip_next = {(trip_reg[1] & cc2_req) | fault_cc2, (trip_reg[0] & cc1_req) | fault_cc1};
  assign blank1_next = !want1 ? '0 : (settled1 ? blank1_reg : blank1_reg + 1'b1);
  assign blank2_next = !want2 ? '0 : (settled2 ? blank2_reg : blank2_reg + 1'b1);

  // Discharge runs only from start until safe 0V, the time limit or port disable
  wire dsc_end = vbus_safe0 | (dcnt_reg == DSC_LAST) | ~port_en;
  assign dsc_timeout = (dst_reg == dppc_pkg::DSC_RUN) & (dcnt_reg == DSC_LAST) & ~vbus_safe0;
  assign discharge_en = (dst_reg == dppc_pkg::DSC_RUN) & port_en;

  always_comb begin
    dst_next = dst_reg;
    dcnt_next = dcnt_reg;
    case (dst_reg)
      dppc_pkg::DSC_IDLE: begin
        dcnt_next = '0;
        if (dsc_start && port_en && !vbus_safe0) begin
          dst_next = dppc_pkg::DSC_RUN;
        end
      end
      dppc_pkg::DSC_RUN: begin
        dcnt_next = dcnt_reg + 1'b1;
        if (dsc_end) begin
          dst_next = dppc_pkg::DSC_IDLE;
        end
      end
      default: dst_next = dppc_pkg::DSC_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trip_reg <= 2'h0;
      blank1_reg <= '0;
      blank2_reg <= '0;
      dcnt_reg <= '0;
      dst_reg <= dppc_pkg::DSC_IDLE;
    end else begin
      trip_reg <= trip_next;
      blank1_reg <= blank1_next;
      blank2_reg <= blank2_next;
      dcnt_reg <= dcnt_next;
      dst_reg <= dst_next;
    end
  end

endmodule // dppc_typec

//--- src/dppc_top.sv
// Downstream port power control: power pins, VCONN, discharge, faults
// Behaviour
// - Port 1 CC1 VCONN enable active high
// - Port 1 CC2 VCONN enable active high
// - CC1 VCONN fault when not above 3.0V
// - CC2 VCONN fault when not above 3.0V
// - Port 1 discharge enable active high
// - Discharge only briefly, 5V down to 0V
// - Enabled port: power pin is pulled-up input
// - Enabled port: watch pin for low overcurrent
// - Disabled port: power pin driven low
// - Ports 1, 2, 4 pin governs whole port
// - Port 3 pin: USB 2.0 only in split
// - Split mode: separate port 3 superspeed enable
// - Port 2 has same VCONN and discharge
module dppc_top #(
  parameter int DISCHARGE_MAX = dppc_pkg::DISCHARGE_MAX_CYC
) (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RST_N,
  // Register port
  input wire logic [dppc_pkg::ADDR_W-1:0] ADDR,
  input wire logic [dppc_pkg::DATA_W-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [dppc_pkg::DATA_W-1:0] RDATA,
  // Interrupt
  output logic IRQ,
  // Port power / overcurrent pins
  input wire logic PORT1_POWER_OC_PIN_I,
  output logic PORT1_POWER_OC_PIN_O,
  output logic PORT1_POWER_OC_PIN_OE,
  output logic PORT1_POWER_OC_PIN_PU,
  input wire logic PORT2_POWER_OC_PIN_I,
  output logic PORT2_POWER_OC_PIN_O,
  output logic PORT2_POWER_OC_PIN_OE,
  output logic PORT2_POWER_OC_PIN_PU,
  input wire logic PORT3_POWER_OC_PIN_I,
  output logic PORT3_POWER_OC_PIN_O,
  output logic PORT3_POWER_OC_PIN_OE,
  output logic PORT3_POWER_OC_PIN_PU,
  input wire logic PORT4_POWER_OC_PIN_I,
  output logic PORT4_POWER_OC_PIN_O,
  output logic PORT4_POWER_OC_PIN_OE,
  output logic PORT4_POWER_OC_PIN_PU,
  // Port 3 superspeed power enable
  output logic PORT3_SUPERSPEED_POWER_EN,
  // Type-C sense
  input wire logic PORT1_CC1_ABOVE_3V0,
  input wire logic PORT1_CC2_ABOVE_3V0,
  input wire logic PORT2_CC1_ABOVE_3V0,
  input wire logic PORT2_CC2_ABOVE_3V0,
  input wire logic PORT1_VBUS_SAFE0,
  input wire logic PORT2_VBUS_SAFE0,
  // Type-C drives
  output logic PORT1_VCONN_CC1_EN,
  output logic PORT1_VCONN_CC2_EN,
  output logic PORT1_VBUS_DISCHARGE_EN,
  output logic PORT2_VCONN_CC1_EN,
  output logic PORT2_VCONN_CC2_EN,
  output logic PORT2_VBUS_DISCHARGE_EN
);

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  function automatic logic hit(input logic [dppc_pkg::ADDR_W-1:0] a,
                               input logic [7:0] off);
    hit = (a == off);
  endfunction

  wire wr_ctrl = WR & hit(ADDR, dppc_pkg::CTRL_OFF);
  wire wr_typec = WR & hit(ADDR, dppc_pkg::TYPEC_OFF);
  wire wr_status = WR & hit(ADDR, dppc_pkg::STATUS_OFF);
  wire wr_mask = WR & hit(ADDR, dppc_pkg::MASK_OFF);
  wire rd_ctrl = hit(ADDR, dppc_pkg::CTRL_OFF);
  wire rd_typec = hit(ADDR, dppc_pkg::TYPEC_OFF);
  wire rd_status = hit(ADDR, dppc_pkg::STATUS_OFF);
  wire rd_mask = hit(ADDR, dppc_pkg::MASK_OFF);
  wire rd_live = hit(ADDR, dppc_pkg::LIVE_OFF);

  // ----------------------------------------
  // Software registers
  // ----------------------------------------
  logic [5:0] ctrl_reg;
  logic [5:0] ctrl_next;
  logic [7:0] typec_reg;
  logic [7:0] typec_next;
  logic [dppc_pkg::ST_W-1:0] status_reg;
  logic [dppc_pkg::ST_W-1:0] status_next;
  logic [dppc_pkg::ST_W-1:0] mask_reg;
  logic [dppc_pkg::ST_W-1:0] mask_next;
  logic [dppc_pkg::DATA_W-1:0] rdata_reg;
  logic [dppc_pkg::DATA_W-1:0] rdata_next;

  // Discharge start bits are pulses and are not stored
  assign ctrl_next = wr_ctrl ? WDATA[5:0] : ctrl_reg;
  assign typec_next = wr_typec ? (WDATA[7:0] & 8'h33) : typec_reg;
  assign mask_next = wr_mask ? WDATA[dppc_pkg::ST_W-1:0] : mask_reg;

  wire [dppc_pkg::NPORT-1:0] port_en = ctrl_reg[dppc_pkg::NPORT-1:0];
  wire split_mode = ctrl_reg[dppc_pkg::CTRL_SPLIT_BIT];
  wire port3_ss_req = ctrl_reg[dppc_pkg::CTRL_SS3_BIT];
  wire p1_dsc_start = wr_typec & WDATA[dppc_pkg::TC_DSC_BIT];
  wire p2_dsc_start = wr_typec & WDATA[dppc_pkg::TC_P2_BASE + dppc_pkg::TC_DSC_BIT];

  // ----------------------------------------
  // Input synchronisation
  // ----------------------------------------
  logic [dppc_pkg::NSYNC-1:0] sync_out;
  wire [dppc_pkg::NSYNC-1:0] sync_in = {
    PORT2_VBUS_SAFE0, PORT1_VBUS_SAFE0,
    PORT2_CC2_ABOVE_3V0, PORT2_CC1_ABOVE_3V0,
    PORT1_CC2_ABOVE_3V0, PORT1_CC1_ABOVE_3V0,
    PORT4_POWER_OC_PIN_I, PORT3_POWER_OC_PIN_I,
    PORT2_POWER_OC_PIN_I, PORT1_POWER_OC_PIN_I
  };

  dppc_sync #(
    .W(dppc_pkg::NSYNC),
    .RST_VAL(10'h00f)
  ) u_sync (
    .clk(CORE_CLK),
    .rst_n(RST_N),
    .d_in(sync_in),
    .d_out(sync_out)
  );

  wire [dppc_pkg::NPORT-1:0] pin_level = sync_out[3:0];
  wire [3:0] cc_ok = sync_out[7:4];
  wire [1:0] safe0 = sync_out[9:8];

  // ----------------------------------------
  // Power pins
  // ----------------------------------------
  // Enabled: released, pulled up; disabled: driven low
  wire [dppc_pkg::NPORT-1:0] pin_oe = ~port_en;
  wire [dppc_pkg::NPORT-1:0] pin_pu = port_en;
  // One pin powers the whole port for 1, 2 and 4, and port 3 outside split
  assign PORT1_POWER_OC_PIN_O = 1'b0;
  assign PORT2_POWER_OC_PIN_O = 1'b0;
  assign PORT3_POWER_OC_PIN_O = 1'b0;
  assign PORT4_POWER_OC_PIN_O = 1'b0;
  assign PORT1_POWER_OC_PIN_OE = pin_oe[0];
  assign PORT2_POWER_OC_PIN_OE = pin_oe[1];
  assign PORT3_POWER_OC_PIN_OE = pin_oe[2];
  assign PORT4_POWER_OC_PIN_OE = pin_oe[3];
  assign PORT1_POWER_OC_PIN_PU = pin_pu[0];
  assign PORT2_POWER_OC_PIN_PU = pin_pu[1];
  assign PORT3_POWER_OC_PIN_PU = pin_pu[2];
  assign PORT4_POWER_OC_PIN_PU = pin_pu[3];

  // ----------------------------------------
  // Port 3 superspeed enable
  // ----------------------------------------
  // Split mode: separate superspeed enable for port 3
  logic ss3_reg;
  wire ss3_next = split_mode & port_en[2] & port3_ss_req;
  // Gated so it drops together with the port 3 pin
  assign PORT3_SUPERSPEED_POWER_EN = ss3_reg & port_en[2];

  // ----------------------------------------
  // Overcurrent
  // ----------------------------------------
  // Synchronised level lags a newly released pin by two edges
  logic [dppc_pkg::NPORT-1:0] en_d1_reg;
  logic [dppc_pkg::NPORT-1:0] en_d2_reg;
  wire [dppc_pkg::NPORT-1:0] en_d1_next = port_en;
  wire [dppc_pkg::NPORT-1:0] en_d2_next = en_d1_reg;
  // Low level on a released pin, once its level has settled
  wire [dppc_pkg::NPORT-1:0] oc_event = port_en & en_d2_reg & ~pin_level;

  // ----------------------------------------
  // Type-C ports
  // ----------------------------------------
  logic p1_fault1;
  logic p1_fault2;
  logic p1_tmo;
  logic p1_dsc;
  logic p2_fault1;
  logic p2_fault2;
  logic p2_tmo;
  logic p2_dsc;
  logic p1_v1;
  logic p1_v2;
  logic p2_v1;
  logic p2_v2;

  dppc_typec #(
    .DSC_MAX(DISCHARGE_MAX)
  ) u_port1 (
    .clk(CORE_CLK),
    .rst_n(RST_N),
    .port_en(port_en[0]),
    .cc1_req(typec_reg[dppc_pkg::TC_CC1_BIT]),
    .cc2_req(typec_reg[dppc_pkg::TC_CC2_BIT]),
    .dsc_start(p1_dsc_start),
    .cc1_ok(cc_ok[0]),
    .cc2_ok(cc_ok[1]),
    .vbus_safe0(safe0[0]),
    .vconn_cc1_en(p1_v1),
    .vconn_cc2_en(p1_v2),
    .discharge_en(p1_dsc),
    .fault_cc1(p1_fault1),
    .fault_cc2(p1_fault2),
    .dsc_timeout(p1_tmo)
  );

  dppc_typec #(
    .DSC_MAX(DISCHARGE_MAX)
  ) u_port2 (
    .clk(CORE_CLK),
    .rst_n(RST_N),
    .port_en(port_en[1]),
    .cc1_req(typec_reg[dppc_pkg::TC_P2_BASE + dppc_pkg::TC_CC1_BIT]),
    .cc2_req(typec_reg[dppc_pkg::TC_P2_BASE + dppc_pkg::TC_CC2_BIT]),
    .dsc_start(p2_dsc_start),
    .cc1_ok(cc_ok[2]),
    .cc2_ok(cc_ok[3]),
    .vbus_safe0(safe0[1]),
    .vconn_cc1_en(p2_v1),
    .vconn_cc2_en(p2_v2),
    .discharge_en(p2_dsc),
    .fault_cc1(p2_fault1),
    .fault_cc2(p2_fault2),
    .dsc_timeout(p2_tmo)
  );

  // ----------------------------------------
  // Type-C pin drives
  // ----------------------------------------
  assign PORT1_VCONN_CC1_EN = p1_v1;
  assign PORT1_VCONN_CC2_EN = p1_v2;
  assign PORT1_VBUS_DISCHARGE_EN = p1_dsc;
  assign PORT2_VCONN_CC1_EN = p2_v1;
  assign PORT2_VCONN_CC2_EN = p2_v2;
  assign PORT2_VBUS_DISCHARGE_EN = p2_dsc;

  // ----------------------------------------
  // Status, mask and interrupt
  // ----------------------------------------
  // Event bits, in status register order
  wire [dppc_pkg::ST_W-1:0] st_set = {
    p2_tmo, p1_tmo,
    p2_fault2, p2_fault1,
    p1_fault2, p1_fault1,
    oc_event
  };
  wire [dppc_pkg::ST_W-1:0] st_clr = wr_status ? WDATA[dppc_pkg::ST_W-1:0] : '0;
  // Set wins over a same-cycle clear
  assign status_next = (status_reg & ~st_clr) | st_set;

  // ----------------------------------------
  // Interrupt
  // ----------------------------------------
  assign IRQ = |(status_reg & mask_reg);

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  wire [dppc_pkg::DATA_W-1:0] live_word = {
    16'h0000,
    p2_v2, p2_v1, p1_v2, p1_v1,
    p2_dsc, p1_dsc, safe0,
    cc_ok, pin_level
  };
  // Discharge activity reads back in place of the start bits
  wire [dppc_pkg::DATA_W-1:0] typec_word = {
    24'h000000,
    1'b0, p2_dsc, typec_reg[5:4],
    1'b0, p1_dsc, typec_reg[1:0]
  };
  wire [dppc_pkg::DATA_W-1:0] rd_mux =
    rd_ctrl ? {26'h0000000, ctrl_reg} :
    rd_typec ? typec_word :
    rd_status ? {22'h000000, status_reg} :
    rd_mask ? {22'h000000, mask_reg} :
    rd_live ? live_word :
    32'h00000000;
  // Data stand only in the cycle after the strobe
  assign rdata_next = RD ? rd_mux : 32'h00000000;
  assign RDATA = rdata_reg;

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl_reg <= dppc_pkg::CTRL_RST;
      typec_reg <= dppc_pkg::TYPEC_RST;
    end else begin
      ctrl_reg <= ctrl_next;
      typec_reg <= typec_next;
    end
  end

  // ----------------------------------------
  // Status and mask registers
  // ----------------------------------------
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      status_reg <= dppc_pkg::STATUS_RST;
      mask_reg <= dppc_pkg::MASK_RST;
    end else begin
      status_reg <= status_next;
      mask_reg <= mask_next;
    end
  end

  // ----------------------------------------
  // Read data register
  // ----------------------------------------
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rdata_reg <= 32'h00000000;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // ----------------------------------------
  // Superspeed enable register
  // ----------------------------------------
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ss3_reg <= 1'b0;
    end else begin
      ss3_reg <= ss3_next;
    end
  end

  // ----------------------------------------
  // Port enable history
  // ----------------------------------------
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      en_d1_reg <= '0;
      en_d2_reg <= '0;
    end else begin
      en_d1_reg <= en_d1_next;
      en_d2_reg <= en_d2_next;
    end
  end

endmodule // dppc_top

//--- verif/dppc_assertions.sv
// Concurrent checks on the power control block's ports
module dppc_assertions #(
  parameter int DISCHARGE_MAX = 50
) (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RST_N,
  // Register port
  input wire logic RD,
  input wire logic [31:0] RDATA,
  // Power pins
  input wire logic PORT1_POWER_OC_PIN_O,
  input wire logic PORT1_POWER_OC_PIN_OE,
  input wire logic PORT1_POWER_OC_PIN_PU,
  input wire logic PORT3_POWER_OC_PIN_OE,
  input wire logic PORT3_POWER_OC_PIN_PU,
  input wire logic PORT3_SUPERSPEED_POWER_EN,
  // Type-C
  input wire logic PORT1_CC1_ABOVE_3V0,
  input wire logic PORT1_VBUS_SAFE0,
  input wire logic PORT1_VCONN_CC1_EN,
  input wire logic PORT1_VCONN_CC2_EN,
  input wire logic PORT1_VBUS_DISCHARGE_EN,
  input wire logic PORT2_VBUS_DISCHARGE_EN
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RST_N);
  logic [15:0] cc_cnt;
  logic [15:0] dsc_cnt;

  // ----------------------------------------
  // Run lengths of unsensed VCONN and discharge
  // ----------------------------------------
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      cc_cnt <= '0;
      dsc_cnt <= '0;
    end else begin
      cc_cnt <= (PORT1_VCONN_CC1_EN && !PORT1_CC1_ABOVE_3V0) ? cc_cnt + 16'h1 : '0;
      dsc_cnt <= PORT2_VBUS_DISCHARGE_EN ? dsc_cnt + 16'h1 : '0;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  chk_pin_drive_low: assert property (PORT1_POWER_OC_PIN_OE |->
    !PORT1_POWER_OC_PIN_PU && !PORT1_POWER_OC_PIN_O) else $error("driven pin not low");
  chk_pin_pull_up: assert property (!PORT3_POWER_OC_PIN_OE |->
    PORT3_POWER_OC_PIN_PU) else $error("enabled pin lacks pull-up");
  chk_reset_safe: assert property ($rose(RST_N) |-> PORT1_POWER_OC_PIN_OE &&
    !PORT1_VCONN_CC1_EN && !PORT1_VBUS_DISCHARGE_EN) else $error("unsafe after reset");
  chk_vconn_port_on: assert property ((PORT1_VCONN_CC1_EN || PORT1_VCONN_CC2_EN) |->
    !PORT1_POWER_OC_PIN_OE) else $error("vconn on disabled port");
  chk_ss_split_en: assert property (PORT3_SUPERSPEED_POWER_EN |->
    PORT3_POWER_OC_PIN_PU) else $error("superspeed enable without port");
  chk_rdata_idle: assert property (!$past(RD) |-> RDATA == 32'h0)
    else $error("read data outside read slot");
  chk_dsc_stop: assert property ($rose(PORT1_VBUS_SAFE0) |->
    ##[0:3] !PORT1_VBUS_DISCHARGE_EN) else $error("discharge past safe level");
  chk_dsc_bound: assert property (dsc_cnt <= DISCHARGE_MAX + 2)
    else $error("discharge too long");
  chk_vconn_fault: assert property (cc_cnt < 16'd2100)
    else $error("vconn fault not acted on");
endmodule // dppc_assertions

bind dppc_top dppc_assertions #(.DISCHARGE_MAX(DISCHARGE_MAX)) u_chk (
  .CORE_CLK, .RST_N, .RD, .RDATA, .PORT1_POWER_OC_PIN_O, .PORT1_POWER_OC_PIN_OE,
  .PORT1_POWER_OC_PIN_PU, .PORT3_POWER_OC_PIN_OE, .PORT3_POWER_OC_PIN_PU,
  .PORT3_SUPERSPEED_POWER_EN, .PORT1_CC1_ABOVE_3V0, .PORT1_VBUS_SAFE0,
  .PORT1_VCONN_CC1_EN, .PORT1_VCONN_CC2_EN, .PORT1_VBUS_DISCHARGE_EN,
  .PORT2_VBUS_DISCHARGE_EN
);

//--- verif/dppc_power_model.sv
// Model of external power switches, VCONN supplies and current monitors
module dppc_power_model #(
  parameter int DLY1 = 10,
  parameter int DLY2 = 200
) (
  // Clock
  input wire logic clk,
  // From the block
  input wire logic [3:0] pin_oe,
  input wire logic [3:0] pin_o,
  input wire logic [3:0] pin_pu,
  input wire logic [3:0] vconn_en,
  input wire logic [1:0] dsc_en,
  // Scenario controls
  input wire logic [3:0] oc,
  input wire logic [3:0] supply_ok,
  input wire logic [1:0] vbus_up,
  // To the block
  output logic [3:0] pin_i,
  output logic [3:0] cc_above,
  output logic [1:0] safe0
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt [2] = '{0, 0};
  // Block's low drive wins; monitor pulls low on overcurrent
  assign pin_i = (pin_oe & pin_o) | (~pin_oe & ~oc & pin_pu);
  assign cc_above = vconn_en & supply_ok;
  initial safe0 = 2'b00;
  // VBUS reaches the safe 0V level after some discharge time
  always @(posedge clk) begin
    for (int i = 0; i < 2; i++) begin
      if (vbus_up[i]) begin
        cnt[i] = 0;
        safe0[i] <= 1'b0;
      end else if (dsc_en[i]) begin
        cnt[i] = cnt[i] + 1;
        if (cnt[i] >= (i == 0 ? DLY1 : DLY2)) safe0[i] <= 1'b1;
      end
    end
  end
endmodule // dppc_power_model

//--- verif/downstream_port_power_control_test.sv
// Self-checking bench for downstream port power control
module downstream_port_power_control_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata, rv;
  logic irq, ss;
  logic [3:0] oe, po, pu, pi, vc, ab;
  logic [3:0] oc = 4'h0;
  logic [3:0] ok = 4'hf;
  logic [1:0] ds, s0;
  logic [1:0] up = 2'b00;
  int miscompares = 0;
  int tests_run = 0;

  initial forever #25 clk = ~clk;

  dppc_top #(.DISCHARGE_MAX(50)) dut (
    .CORE_CLK(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .IRQ(irq), .PORT3_SUPERSPEED_POWER_EN(ss),
    .PORT1_POWER_OC_PIN_I(pi[0]), .PORT1_POWER_OC_PIN_O(po[0]),
    .PORT1_POWER_OC_PIN_OE(oe[0]), .PORT1_POWER_OC_PIN_PU(pu[0]),
    .PORT2_POWER_OC_PIN_I(pi[1]), .PORT2_POWER_OC_PIN_O(po[1]),
    .PORT2_POWER_OC_PIN_OE(oe[1]), .PORT2_POWER_OC_PIN_PU(pu[1]),
    .PORT3_POWER_OC_PIN_I(pi[2]), .PORT3_POWER_OC_PIN_O(po[2]),
    .PORT3_POWER_OC_PIN_OE(oe[2]), .PORT3_POWER_OC_PIN_PU(pu[2]),
    .PORT4_POWER_OC_PIN_I(pi[3]), .PORT4_POWER_OC_PIN_O(po[3]),
    .PORT4_POWER_OC_PIN_OE(oe[3]), .PORT4_POWER_OC_PIN_PU(pu[3]),
    .PORT1_CC1_ABOVE_3V0(ab[0]), .PORT1_CC2_ABOVE_3V0(ab[1]),
    .PORT2_CC1_ABOVE_3V0(ab[2]), .PORT2_CC2_ABOVE_3V0(ab[3]),
    .PORT1_VBUS_SAFE0(s0[0]), .PORT2_VBUS_SAFE0(s0[1]),
    .PORT1_VCONN_CC1_EN(vc[0]), .PORT1_VCONN_CC2_EN(vc[1]),
    .PORT2_VCONN_CC1_EN(vc[2]), .PORT2_VCONN_CC2_EN(vc[3]),
    .PORT1_VBUS_DISCHARGE_EN(ds[0]), .PORT2_VBUS_DISCHARGE_EN(ds[1])
  );

  dppc_power_model fsd (
    .clk(clk), .pin_oe(oe), .pin_o(po), .pin_pu(pu), .vconn_en(vc), .dsc_en(ds),
    .oc(oc), .supply_ok(ok), .vbus_up(up), .pin_i(pi), .cc_above(ab), .safe0(s0)
  );

  // ----------------------------------------
  // Bus cycles and comparison
  // ----------------------------------------
  task chk(string n, logic [31:0] got, logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, exp, got);
    end
  endtask

  task cyc(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task wreg(logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask

  task rreg(logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    rv = rdata;
  endtask

  task final_report;
    $display("Checks %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_reset;
    chk("oe", oe, 32'hf);
    chk("pu", pu, 32'h0);
    chk("pin_o", po, 32'h0);
    chk("drives", {ds, vc, ss}, 32'h0);
  endtask

  task t_ports;
    wreg(8'h00, 32'hf);
    chk("oe_all", oe, 32'h0);
    chk("pu_all", pu, 32'hf);
    chk("pin_all", pi, 32'hf);
    wreg(8'h00, 32'h5);
    chk("oe_part", oe, 32'ha);
    chk("pin_part", pi, 32'h5);
    wreg(8'h20, 32'hf);
    rreg(8'h20);
    chk("unmapped", rv, 32'h0);
    rreg(8'h00);
    chk("ctrl", rv, 32'h5);
    rreg(8'h08);
    chk("no_false_oc", rv, 32'h0);
  endtask

  task t_split;
    wreg(8'h00, 32'h34);
    cyc(1);
    chk("ss_on", {ss, pu[2]}, 32'h3);
    wreg(8'h00, 32'h24);
    cyc(1);
    chk("ss_nosplit", {ss, pu[2]}, 32'h1);
    wreg(8'h00, 32'h34);
    cyc(1);
    wreg(8'h00, 32'h30);
    chk("ss_dis", {ss, oe[2]}, 32'h1);
  endtask

  task t_oc;
    wreg(8'h00, 32'hf);
    cyc(4);
    wreg(8'h08, 32'h3ff);
    oc <= 4'h2;
    cyc(5);
    chk("oc_pin", pi, 32'hd);
    rreg(8'h08);
    chk("oc_status", rv, 32'h2);
    chk("irq_masked", irq, 32'h0);
    wreg(8'h0c, 32'h2);
    chk("irq_on", irq, 32'h1);
    rreg(8'h0c);
    chk("mask_rd", rv, 32'h2);
    oc <= 4'h0;
    cyc(4);
    wreg(8'h08, 32'h2);
    rreg(8'h08);
    chk("oc_clear", rv, 32'h0);
    chk("irq_off", irq, 32'h0);
  endtask

  task t_vconn;
    wreg(8'h00, 32'h3);
    wreg(8'h08, 32'h3ff);
    ok <= 4'h6;
    wreg(8'h04, 32'h33);
    chk("vconn_on", vc, 32'hf);
    cyc(2020);
    chk("vconn_fault", vc, 32'h6);
    rreg(8'h08);
    chk("fault_status", rv, 32'h90);
    wreg(8'h04, 32'h0);
    chk("vconn_off", vc, 32'h0);
    wreg(8'h04, 32'h22);
    wreg(8'h00, 32'h1);
    chk("vconn_dis", vc, 32'h2);
    wreg(8'h04, 32'h0);
  endtask

  task t_dsc;
    wreg(8'h00, 32'h3);
    wreg(8'h08, 32'h3ff);
    wreg(8'h04, 32'h44);
    chk("dsc_on", ds, 32'h3);
    cyc(20);
    chk("dsc_fast", {ds, s0}, 32'h9);
    cyc(40);
    chk("dsc_tmo", ds, 32'h0);
    rreg(8'h08);
    chk("tmo_status", rv, 32'h200);
    wreg(8'h04, 32'h4);
    chk("dsc_at_safe", ds, 32'h0);
    up <= 2'b11;
    cyc(4);
    wreg(8'h00, 32'h1);
    wreg(8'h04, 32'h44);
    chk("dsc_one", ds, 32'h1);
    rreg(8'h10);
    chk("live", rv, 32'h401);
    rreg(8'h04);
    chk("typec_rd", rv, 32'h4);
    wreg(8'h00, 32'h0);
    chk("dsc_stop", ds, 32'h0);
  endtask

  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    cyc(1);
    t_reset;
    t_ports;
    t_split;
    t_oc;
    t_vconn;
    t_dsc;
    final_report;
  end

  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    final_report;
  end
endmodule // downstream_port_power_control_test
